// *** logic/sbst_pkg.sv ***
package sbst_pkg;

  // register sizes
  localparam int IR_W   = 3;
  localparam int ID_W   = 32;
  localparam int BSR_W  = 109;
  localparam int RING_W = 108;

  // position of the internal driver-enable cell
  localparam int DRV_CELL = 108;

  // instruction codes
  localparam logic [2:0] INS_EXTEST  = 3'h0;
  localparam logic [2:0] INS_IDCODE  = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_PRELOAD = 3'h4;
  localparam logic [2:0] INS_BYPASS  = 3'h7;

  // instruction capture pattern and reset value
  localparam logic [2:0] IR_CAPTURE  = 3'h1;
  localparam logic [2:0] IR_RESET    = INS_IDCODE;

  // identification fields; all values arbitrary
  localparam logic [2:0]  ID_REVISION = 3'h0;
  localparam logic [16:0] ID_PART     = 17'h00a5a;
  localparam logic [10:0] ID_MAKER    = 11'h155;
  localparam logic        ID_PRESENT  = 1'h1;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  // controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
  } sbst_state_t;

endpackage

// *** logic/sbst_sync.sv ***
`timescale 1ns/1ps
// two-flop level synchroniser, one lane per bit
module sbst_sync #(
  parameter int W = 1
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level from another domain
  input  wire logic [W-1:0] d,
  // synchronised level
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;  // first stage, read only by the second

  // both stages clear at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// *** logic/sbst_tap.sv ***
`timescale 1ns/1ps
// boundary-scan test port of a synchronous memory
module sbst_tap (
  // system side
  input  wire logic         SYS_CLK,
  input  wire logic         RESETN,
  // test link
  input  wire logic         TCK,
  input  wire logic         TMS,
  input  wire logic         TDI,
  output logic              TDO_O,
  output logic              TDO_OE,
  // pin ring
  input  wire logic [107:0] RING_IN,
  output logic      [107:0] RING_OUT,
  output logic              EXTEST_ON,
  // read-data driver enable, system domain
  output logic              Q_DRV_EN
);

  sbst_pkg::sbst_state_t state_ff;   // controller state
  sbst_pkg::sbst_state_t nxt_state;  // next controller state

  logic [2:0]   ir_sh_ff;            // instruction shift stage
  logic [2:0]   ir_ff;               // active instruction
  logic         byp_ff;              // bypass cell
  logic [31:0]  id_sh_ff;            // identification shift stage
  logic [108:0] bsr_ff;              // boundary shift chain
  logic [108:0] upd_ff;              // boundary update latches
  logic         drv_tck_ff;          // driver enable in link domain
  logic [107:0] ring_sync;           // pin ring after two flops
  logic         drv_sync;            // driver disable after two flops

  // instruction decode
  wire sel_extest  = (ir_ff == sbst_pkg::INS_EXTEST);
  wire sel_idcode  = (ir_ff == sbst_pkg::INS_IDCODE);
  wire sel_samplez = (ir_ff == sbst_pkg::INS_SAMPLEZ);
  wire sel_preload = (ir_ff == sbst_pkg::INS_PRELOAD);
  // chain users; reserved codes fall to bypass, harmless if misused
  wire sel_chain   = sel_extest | sel_samplez | sel_preload;
  wire sel_bypass  = !sel_chain && !sel_idcode;

  // hardwired identification word
  wire [31:0] id_word = {sbst_pkg::ID_REVISION, sbst_pkg::ID_PART,
                         sbst_pkg::ID_MAKER, sbst_pkg::ID_PRESENT};

  // state qualifiers
  wire in_reset = (state_ff == sbst_pkg::ST_RESET);
  wire cap_dr   = (state_ff == sbst_pkg::ST_CAP_DR);
  wire sh_dr    = (state_ff == sbst_pkg::ST_SH_DR);
  wire up_dr    = (state_ff == sbst_pkg::ST_UP_DR);
  wire cap_ir   = (state_ff == sbst_pkg::ST_CAP_IR);
  wire sh_ir    = (state_ff == sbst_pkg::ST_SH_IR);
  wire up_ir    = (state_ff == sbst_pkg::ST_UP_IR);

  // serial bit presented toward tdo
  wire dr_bit   = sel_chain  ? bsr_ff[0] :
                  sel_idcode ? id_sh_ff[0] : byp_ff;
  wire tdo_bit  = sh_ir ? ir_sh_ff[0] : dr_bit;

  // the link clock may stop right after an update rise, so every output
  // below is loaded from next values on that same rise rather than
  // trailing the latches by one more rise that might never come

  // active instruction after this rise; test reset restores the default
  // an instruction only takes effect once its update rise has passed
  wire [2:0] nxt_ir      = in_reset ? sbst_pkg::IR_RESET :
                           up_ir    ? ir_sh_ff :            // update loads it
                                      ir_ff;                // otherwise held

  // update latches load the chain only under external test or preload
  // sample-z only captures, so its scans never disturb the pin latches
  wire       upd_load    = up_dr && (sel_extest || sel_preload);

  // cell 108 after this rise, preset high by test reset
  wire       nxt_cell    = in_reset ? 1'b1 :
                           upd_load ? bsr_ff[sbst_pkg::DRV_CELL] :  // freshly latched
                                      upd_ff[sbst_pkg::DRV_CELL];   // held

  // driver enable: cell 108 under extest, forced off under sample-z
  wire       drv_en      = (nxt_ir == sbst_pkg::INS_EXTEST)  ? nxt_cell :
                           (nxt_ir == sbst_pkg::INS_SAMPLEZ) ? 1'b0 :
                                                               1'b1;       // drivers on

  // inverted for the synchroniser, whose stages clear to zero
  wire       drv_off_tck = !drv_tck_ff;

  // controller transitions; tms high walks to reset within five edges
  // from any state, so a controller that lost track of the walk can
  // always recover without touching the power-up reset
  always_comb begin
    unique case (state_ff)
      sbst_pkg::ST_RESET:  nxt_state = TMS ? sbst_pkg::ST_RESET  : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_IDLE:   nxt_state = TMS ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_DR: nxt_state = TMS ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
      sbst_pkg::ST_CAP_DR: nxt_state = TMS ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_SH_DR:  nxt_state = TMS ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_EX1_DR: nxt_state = TMS ? sbst_pkg::ST_UP_DR  : sbst_pkg::ST_PA_DR;
      sbst_pkg::ST_PA_DR:  nxt_state = TMS ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PA_DR;
      sbst_pkg::ST_EX2_DR: nxt_state = TMS ? sbst_pkg::ST_UP_DR  : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_UP_DR:  nxt_state = TMS ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_IR: nxt_state = TMS ? sbst_pkg::ST_RESET  : sbst_pkg::ST_CAP_IR;
      sbst_pkg::ST_CAP_IR: nxt_state = TMS ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_SH_IR:  nxt_state = TMS ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_EX1_IR: nxt_state = TMS ? sbst_pkg::ST_UP_IR  : sbst_pkg::ST_PA_IR;
      sbst_pkg::ST_PA_IR:  nxt_state = TMS ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PA_IR;
      sbst_pkg::ST_EX2_IR: nxt_state = TMS ? sbst_pkg::ST_UP_IR  : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_UP_IR:  nxt_state = TMS ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
    endcase
  end

  // controller state, power-up lands in reset
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) state_ff <= sbst_pkg::ST_RESET;
    else         state_ff <= nxt_state;
  end

  // instruction path: capture 01, shift lsb first, update on exit
  // reserved codes are loaded as given and simply select the bypass cell
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      ir_sh_ff <= sbst_pkg::IR_RESET;
      ir_ff    <= sbst_pkg::IR_RESET;
    end else begin
      if (cap_ir)     ir_sh_ff <= sbst_pkg::IR_CAPTURE;
      else if (sh_ir) ir_sh_ff <= {TDI, ir_sh_ff[2:1]};
      if (in_reset)   ir_ff <= sbst_pkg::IR_RESET;
      else if (up_ir) ir_ff <= ir_sh_ff;
    end
  end

  // bypass and identification shift stages
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      byp_ff   <= 1'b0;
      id_sh_ff <= '0;
    end else begin
      if (cap_dr && sel_bypass)     byp_ff <= 1'b0;
      else if (sh_dr && sel_bypass) byp_ff <= TDI;
      if (cap_dr && sel_idcode)     id_sh_ff <= id_word;
      else if (sh_dr && sel_idcode) id_sh_ff <= {TDI, id_sh_ff[31:1]};
    end
  end

  // boundary chain: capture the ring, shift from msb toward lsb
  // cell 108 captures its own latch, so a plain scan reads it back
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      bsr_ff <= '0;
    end else if (cap_dr && sel_chain) begin
      bsr_ff <= {upd_ff[sbst_pkg::DRV_CELL], ring_sync};
    end else if (sh_dr && sel_chain) begin
      bsr_ff <= {TDI, bsr_ff[108:1]};
    end
  end

  // update latches; cell 108 presets high at power-up and test reset,
  // while cells 107:0 keep their last preload through a test reset
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      upd_ff <= {1'b1, 108'h0};
    end else if (in_reset) begin
      upd_ff[sbst_pkg::DRV_CELL] <= 1'b1;
    end else if (upd_load) begin
      upd_ff <= bsr_ff;
    end
  end

  // ring outputs and driver enable held in link-domain flops; the ring
  // outputs always equal latches 107:0 and the flags follow the next
  // instruction, so all three are right once the update rise is over
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      RING_OUT   <= '0;
      EXTEST_ON  <= 1'b0;
      drv_tck_ff <= 1'b1;
    end else begin
      if (upd_load) RING_OUT <= bsr_ff[107:0];
      EXTEST_ON  <= (nxt_ir == sbst_pkg::INS_EXTEST);
      drv_tck_ff <= drv_en;
    end
  end

  // tdo changes on the falling edge, floats outside shift states
  // the controller samples tdo on the rise, half a cycle after it moves
  always_ff @(negedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      TDO_O  <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO_O  <= tdo_bit;
      TDO_OE <= sh_ir | sh_dr;
    end
  end

  // pin ring enters the link domain through two flops
  sbst_sync #(.W(sbst_pkg::RING_W)) u_ring_sync (
    .clk   (TCK),
    .rst_n (RESETN),
    .d     (RING_IN),
    .q     (ring_sync)
  );

  // driver disable crosses into the system domain; the stages clear to
  // zero, so carrying the inverted level keeps the drivers on while the
  // synchroniser refills after reset instead of dropping them briefly
  sbst_sync #(.W(1)) u_drv_sync (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .d     (drv_off_tck),
    .q     (drv_sync)
  );

  // system-domain driver enable output flop, preset high
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) Q_DRV_EN <= 1'b1;
    else         Q_DRV_EN <= !drv_sync;
  end

endmodule

// *** tb/sbst_ctl_model.sv ***
`timescale 1ns/1ps
// test controller; link clock runs only inside frames
module sbst_ctl_model (
  // link pins toward the port
  output logic       TCK,
  output logic       TMS,
  output logic       TDI,
  // serial return
  input  wire logic  TDO_O
);
  // link rests low, mode select high
  initial begin
    TCK = 1'h0;
    TMS = 1'h1;
    TDI = 1'h0;
  end
  // one cycle: drive while low, sample return at the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    TMS = tms;
    TDI = tdi;
    #3 TCK = 1'h1;
    tdo = TDO_O;
    #3 TCK = 1'h0;
  endtask
  // walk to reset with mode select high, then idle
  task automatic tlr();
    logic t;
    repeat (5) step(1'h1, ~TDI, t);
    repeat (16) step(1'h0, ~TDI, t);
  endtask
  // one scan frame, lsb first; ir picks the instruction path
  task automatic shift(input logic ir, input int n, input logic [108:0] din,
                       output logic [108:0] dout);
    logic t;
    dout = '0;
    if (ir && din[2:0] inside {3'h3, 3'h5, 3'h6}) din[2:0] = sbst_pkg::INS_BYPASS;
    step(1'h0, ~TDI, t);
    step(1'h1, ~TDI, t);
    if (ir) step(1'h1, ~TDI, t);
    repeat (2) step(1'h0, ~TDI, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'h1, ~TDI, t);
    step(1'h0, ~TDI, t);
  endtask
endmodule

// *** tb/sbst_tap_asserts.sv ***
`timescale 1ns/1ps
// pin-level checks on the test port
module sbst_tap_chk (
  // link domain
  input wire logic         RESETN,
  input wire logic         TCK,
  input wire logic         TMS,
  // serial return
  input wire logic         TDO_O,
  input wire logic         TDO_OE,
  // pin ring and drivers
  input wire logic [107:0] RING_OUT,
  input wire logic         EXTEST_ON,
  input wire logic         Q_DRV_EN
);
  default clocking cb @(posedge TCK);
  endclocking
  default disable iff (!RESETN);
  // serial return as seen at the last rise
  logic tdo_ff;
  logic oe_ff;
  // capture return levels at each rise
  always_ff @(posedge TCK or negedge RESETN) begin
    if (!RESETN) begin
      tdo_ff <= 1'h0;
      oe_ff  <= 1'h0;
    end else begin
      tdo_ff <= TDO_O;
      oe_ff  <= TDO_OE;
    end
  end
  // five high rises, then seventeen idle rises
  sequence s_tlr;
    TMS [*5] ##1 !TMS [*8] ##1 !TMS [*8] ##1 !TMS;
  endsequence
  a_tdo_fall_only:
  assert property (@(negedge TCK) TDO_O == tdo_ff && TDO_OE == oe_ff)
    else $error("serial return moved off the falling edge");
  a_ir_capture:
  assert property (s_tlr ##1 TMS [*2] ##1 !TMS [*2] ##1 !TMS
    |-> TDO_O && TDO_OE ##1 !TDO_O && TDO_OE) else $error("capture pattern wrong");
  a_id_lsbs:
  assert property (s_tlr ##1 TMS ##1 !TMS [*2] ##1 !TMS [*3]
    |-> $past(TDO_O, 2) && $past(TDO_O) && !TDO_O) else $error("id low bits wrong");
  a_drv_tlr:
  assert property (s_tlr |-> Q_DRV_EN) else $error("driver enable not restored");
  a_reset_ext:
  assert property (TMS [*5] |-> ##[1:3] !EXTEST_ON) else $error("external test kept");
  a_ring_upd:
  assert property ($changed(RING_OUT) |-> $past(TMS) || $past(TMS, 2) || $past(TMS, 3))
    else $error("ring latches moved without update");
  a_ext_upd:
  assert property ($changed(EXTEST_ON) |-> $past(TMS) || $past(TMS, 2) || $past(TMS, 3))
    else $error("instruction moved without update");
  a_oe_track:
  assert property (TDO_OE |=> TDO_OE == !$past(TMS)) else $error("shift enable wrong");
endmodule
bind sbst_tap sbst_tap_chk u_chk (
  .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDO_O(TDO_O), .TDO_OE(TDO_OE),
  .RING_OUT(RING_OUT), .EXTEST_ON(EXTEST_ON), .Q_DRV_EN(Q_DRV_EN)
);

// *** tb/tb_sbst_tap.sv ***
`timescale 1ns/1ps
// scans the port through the controller model
module tb_sbst_tap;
  // system side and pin ring
  logic         SYS_CLK;
  logic         RESETN;
  logic [107:0] RING_IN;
  // link and outputs
  wire          TCK, TMS, TDI, TDO_O, TDO_OE, EXTEST_ON, Q_DRV_EN;
  wire  [107:0] RING_OUT;
  // tallies and scan data
  int           n_fail;
  int           checks_done;
  logic [108:0] d;
  // identification word and ring patterns
  localparam logic [31:0]  ID_WORD = {sbst_pkg::ID_REVISION, sbst_pkg::ID_PART,
                                      sbst_pkg::ID_MAKER, sbst_pkg::ID_PRESENT};
  localparam logic [107:0] PAT = {27{4'h9}};
  localparam logic [107:0] Q   = {27{4'h3}};
  // system clock
  initial begin
    SYS_CLK = 1'h0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  sbst_tap uut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO_O(TDO_O), .TDO_OE(TDO_OE), .RING_IN(RING_IN), .RING_OUT(RING_OUT),
    .EXTEST_ON(EXTEST_ON), .Q_DRV_EN(Q_DRV_EN));
  sbst_ctl_model ctl (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO_O(TDO_O));
  // compare one scan-width value
  task automatic cmp(input logic [108:0] got, input logic [108:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // power-up reset while the link walks to reset
  task automatic pwr_reset();
    @(negedge SYS_CLK) RESETN = 1'h0;
    fork
      ctl.tlr();
    join_none
    repeat (16) @(negedge SYS_CLK);
    cmp({106'h0, TDO_OE, Q_DRV_EN, EXTEST_ON}, 109'h2);
    cmp({1'h0, RING_OUT}, 109'h0);
    @(negedge SYS_CLK) RESETN = 1'h1;
    repeat (2) @(negedge SYS_CLK);
    cmp({108'h0, Q_DRV_EN}, 109'h1);
  endtask
  // instruction frame, checks the captured pattern
  task automatic ir(input logic [2:0] c);
    ctl.shift(1'h1, 3, {106'h0, c}, d);
    cmp(d, 109'h1);
  endtask
  // data frame
  task automatic dr(input int n, input logic [108:0] din);
    ctl.shift(1'h0, n, din, d);
  endtask
  // lets the driver enable cross into the system domain
  task automatic settle();
    repeat (4) @(negedge SYS_CLK);
  endtask
  // verdict
  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    RESETN = 1'h0;
    RING_IN = ~PAT;
    pwr_reset();
    dr(32, 109'h0);
    cmp(d, {77'h0, ID_WORD});
    ctl.tlr();
    ir(sbst_pkg::INS_BYPASS);
    dr(2, 109'h1);
    cmp(d, 109'h2);
    @(negedge SYS_CLK) RING_IN = PAT;
    ir(sbst_pkg::INS_PRELOAD);
    dr(109, {1'h0, Q});
    cmp(d, {1'h1, PAT});
    cmp({1'h0, RING_OUT}, {1'h0, Q});
    ir(sbst_pkg::INS_EXTEST);
    settle();
    cmp({107'h0, EXTEST_ON, Q_DRV_EN}, 109'h2);
    dr(109, {1'h1, ~Q});
    cmp(d, {1'h0, PAT});
    settle();
    cmp({107'h0, EXTEST_ON, Q_DRV_EN}, 109'h3);
    dr(109, {1'h0, ~Q});
    cmp(d, {1'h1, PAT});
    cmp({1'h0, RING_OUT}, {1'h0, ~Q});
    ctl.tlr();
    dr(32, 109'h0);
    cmp(d, {77'h0, ID_WORD});
    settle();
    cmp({107'h0, EXTEST_ON, Q_DRV_EN}, 109'h1);
    ir(sbst_pkg::INS_SAMPLEZ);
    settle();
    cmp({108'h0, Q_DRV_EN}, 109'h0);
    dr(109, 109'h0);
    cmp(d, {1'h1, PAT});
    cmp({1'h0, RING_OUT}, {1'h0, ~Q});
    pwr_reset();
    wrap_up();
  end
endmodule
